//--- include/dssr_pkg.sv
// constants, encodings and reset values of the link status block.
// assumes one 100 MHz system clock.
package dssr_pkg;

  // --------------------------------------------------------------
  // clock and timing
  // --------------------------------------------------------------
  localparam int CLK_HZ = 32'h05f5_e100;
  localparam int BAUD_MIN_HZ = 32'h0000_012c;
  localparam int MS_PER_S = 32'h0000_03e8;
  localparam int BIT_CYCLES_300 = CLK_HZ / BAUD_MIN_HZ;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;

  // --------------------------------------------------------------
  // reference and frequency word scaling
  // --------------------------------------------------------------
  localparam logic [15:0] REF_FULL = 16'h4000;
  localparam int REF_SHIFT = 14;
  localparam logic [15:0] WORD_MAX = 16'h7fff;

  // --------------------------------------------------------------
  // status and control word bit positions
  // --------------------------------------------------------------
  localparam int ST_SPEED_AT_REF = 8;
  localparam int ST_SERIAL_OK = 9;
  localparam int ST_IN_RANGE = 10;
  localparam int ST_RUNNING = 11;
  localparam int ST_NO_FUNC = 12;
  localparam int ST_VOLT_WARN = 13;
  localparam int ST_CURR_LIMIT = 14;
  localparam int ST_THERMAL = 15;
  localparam int CW_COAST = 3;
  localparam int CW_VALID = 10;

  // --------------------------------------------------------------
  // setting encodings
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    PROTO_NATIVE = 2'h0,
    PROTO_VENDOR_ONE = 2'h1,
    PROTO_VENDOR_TWO = 2'h2,
    PROTO_MODBUS_RTU = 2'h3
  } dssr_proto_t;

  typedef enum logic [1:0] {
    SRC_DIGITAL = 2'h0,
    SRC_SERIAL = 2'h1,
    SRC_AND = 2'h2,
    SRC_OR = 2'h3
  } dssr_src_t;

  typedef enum logic [1:0] {
    SEL_PROTOCOL = 2'h0,
    SEL_ADDRESS = 2'h1,
    SEL_BAUD = 2'h2,
    SEL_COAST = 2'h3
  } dssr_sel_t;

  localparam dssr_proto_t PROTO_RST = PROTO_NATIVE;
  localparam logic [7:0] ADDR_RST = 8'h01;
  localparam logic [2:0] BAUD_RST = 3'h5;
  localparam dssr_src_t COAST_SRC_RST = SRC_OR;

  // address ranges per protocol
  localparam logic [7:0] ADDR_MAX_NATIVE = 8'h7e;
  localparam logic [7:0] ADDR_MAX_VENDOR_ONE = 8'hff;
  localparam logic [7:0] ADDR_MAX_VENDOR_TWO = 8'h62;
  localparam logic [7:0] ADDR_MAX_MODBUS = 8'hf7;

  // baud codes: code n gives 300 * 2**n baud
  localparam logic [2:0] BAUD_CODE_4800 = 3'h4;
  localparam logic [2:0] BAUD_CODE_9600 = 3'h5;

endpackage : dssr_pkg

//--- hdl/dssr_divider.sv
// serial restoring divider, one quotient bit per clock.
// assumes the caller holds off start while busy is high.
`timescale 1ns/100ps
module dssr_divider
  import dssr_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic reset, // async reset, active high
  input wire logic start, // begin a division
  input wire logic [29:0] dividend, // numerator, taken at start
  input wire logic [15:0] divisor, // denominator, nonzero
  output logic busy, // division in progress
  output logic done, // one-cycle pulse, quotient valid
  output logic [29:0] quotient // result, held until the next division ends
);

  typedef enum logic {DIV_IDLE, DIV_RUN} dssr_div_t;

  dssr_div_t state;
  logic [16:0] rem;
  logic [29:0] work;
  logic [15:0] den;
  logic [4:0] steps;
  wire logic [16:0] shifted = {rem[15:0], work[29]};
  wire logic fits = shifted >= {1'b0, den};
  wire logic [16:0] next_rem = fits ? shifted - {1'b0, den} : shifted;
  wire logic last = steps == 5'h1d;

  assign busy = state == DIV_RUN;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= DIV_IDLE;
      rem <= 17'h0_0000;
      work <= 30'h0000_0000;
      den <= 16'h0000;
      steps <= 5'h00;
      done <= 1'b0;
      quotient <= 30'h0000_0000;
    end else begin
      done <= 1'b0;
      unique case (state)
        DIV_IDLE: begin
          if (start) begin
            rem <= 17'h0_0000;
            work <= dividend;
            den <= divisor;
            steps <= 5'h00;
            state <= DIV_RUN;
          end
        end
        DIV_RUN: begin
          // the dividend shifts out at the top as quotient bits enter
          rem <= next_rem;
          work <= {work[28:0], fits};
          steps <= steps + 5'h01;
          if (last) begin
            quotient <= {work[28:0], fits};
            done <= 1'b1;
            state <= DIV_IDLE;
          end
        end
      endcase
    end
  end

endmodule : dssr_divider

//--- hdl/dssr_top.sv
// link status word, speed reference decode, output frequency word,
// link settings and coast source combining.
// assumes inputs synchronous to sys_clk; conditions and limits come
// from the motor core in one frequency unit.
//
// Contract
// - status bit 8 set when speed equals reference
// - status bit 9 clear on panel stop or hand mode
// - status bit 10 set while frequency is strictly inside limits
// - status bit 11 set on start or frequency above zero
// - status bit 13 set when dc bus voltage is out of bounds
// - status bit 14 flags overcurrent; persisting past trip delay trips
// - status bit 15 set on motor, drive or thermistor overheat
// - reference is 16-bit signed, 0x4000 full scale, up to 200%
// - reference 0 to 16384 maps linearly from minimum to maximum
// - negative two's complement reference means reverse rotation
// - output frequency word scales the same between limits
// - protocol code 0 to 3 selects one of four protocols
// - address range depends on protocol, default address is 1
// - station address writes over the link are refused
// - baud codes 0 to 5 give 300 to 9600 baud, default 9600
// - permitted baud rates depend on the protocol
// - baud rate writes over the link are refused
// - coast source: digital, serial, and, or (default or)
// - serial source uses only the control word
// - and source needs the digital input as well as serial command
// - coast terminal and control word bit 3 are active low
`timescale 1ns/100ps
module dssr_top
  import dssr_pkg::*;
#(
  parameter int BIT_CYCLES_300_P = BIT_CYCLES_300, // cycles per 300 baud bit
  parameter int MS_CYCLES_P = MS_CYCLES // cycles per millisecond
) (
  input wire logic sys_clk, // system clock, 100 MHz
  input wire logic reset, // async reset, active high
  // setting writes
  input wire logic panel_wr, // local_operator_panel write strobe
  input wire logic [1:0] panel_sel, // setting selected by panel
  input wire logic [7:0] panel_data, // panel write value
  input wire logic serial_wr, // serial link setting write strobe
  input wire logic [1:0] serial_sel, // setting selected by link
  input wire logic [7:0] serial_data, // link write value
  output logic setting_refused, // pulse: last write refused
  output logic [1:0] protocol_sel, // selected protocol
  output logic [7:0] station_address, // station address
  output logic [2:0] baud_code, // bit rate code
  output logic [1:0] coast_source, // coasting command source
  output logic baud_tick, // pulse once per bit time
  // control word and coasting
  input wire logic ctrl_wr, // control word strobe from link
  input wire logic [15:0] ctrl_word, // received control word
  input wire logic coast_terminal_n, // coasting input, low coasts
  output logic coast_active, // motor to coast
  // speed reference
  input wire logic ref_wr, // speed_setpoint_word write strobe
  input wire logic [15:0] ref_data, // speed_setpoint_word value
  input wire logic [15:0] min_ref, // configured minimum reference
  input wire logic [15:0] max_ref, // configured maximum reference
  output logic [15:0] speed_target, // decoded speed magnitude
  output logic speed_reverse, // reverse rotation requested
  // condition inputs
  input wire logic [15:0] motor_speed, // actual motor speed
  input wire logic [15:0] out_freq, // present output frequency
  input wire logic out_reverse, // output rotating in reverse
  input wire logic [15:0] freq_low, // output frequency low limit
  input wire logic [15:0] freq_high, // output frequency high limit
  input wire logic start_present, // a start signal is present
  input wire logic panel_stop, // panel off/stop is active
  input wire logic hand_mode, // drive is in hand mode
  input wire logic [15:0] dc_voltage, // intermediate dc bus voltage
  input wire logic [15:0] dc_low, // lower dc voltage bound
  input wire logic [15:0] dc_high, // upper dc voltage bound
  input wire logic [15:0] out_current, // output current
  input wire logic [15:0] current_ceiling_setting, // current limit
  input wire logic [15:0] trip_delay_ms, // overcurrent trip delay
  input wire logic trip_reset, // clears overcurrent trip
  input wire logic motor_hot, // motor over temperature
  input wire logic drive_hot, // drive over temperature
  input wire logic thermistor_hot, // thermistor input over limit
  input wire logic [7:0] status_low, // lower status byte from core
  output logic overcurrent_trip, // overcurrent trip, sticky
  output logic [15:0] drive_state_word, // status word
  output logic [15:0] output_freq_word // scaled output frequency
);

  // --------------------------------------------------------------
  // setting writes
  // --------------------------------------------------------------
  // the panel wins a same-cycle clash; the link write is then dropped
  // and flagged, since only one value can be stored.
  wire logic wr_any = panel_wr | serial_wr;
  wire logic wr_from_link = serial_wr & ~panel_wr;
  wire logic [1:0] wr_sel = panel_wr ? panel_sel : serial_sel;
  wire logic [7:0] wr_data = panel_wr ? panel_data : serial_data;
  wire logic clash = panel_wr & serial_wr;

  function automatic logic addr_ok(input logic [1:0] p,
                                   input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    unique case (dssr_proto_t'(p))
      PROTO_NATIVE: ok = a <= ADDR_MAX_NATIVE;
      PROTO_VENDOR_ONE: ok = a != 8'h00 && a <= ADDR_MAX_VENDOR_ONE;
      PROTO_VENDOR_TWO: ok = a <= ADDR_MAX_VENDOR_TWO;
      PROTO_MODBUS_RTU: ok = a != 8'h00 && a <= ADDR_MAX_MODBUS;
    endcase
    return ok;
  endfunction : addr_ok

  function automatic logic baud_ok(input logic [1:0] p,
                                   input logic [2:0] b);
    logic ok;
    ok = 1'b0;
    unique case (dssr_proto_t'(p))
      PROTO_NATIVE: ok = b <= BAUD_CODE_9600;
      PROTO_VENDOR_ONE: ok = b == BAUD_CODE_9600;
      PROTO_VENDOR_TWO: ok = b >= BAUD_CODE_4800 && b <= BAUD_CODE_9600;
      PROTO_MODBUS_RTU: ok = b <= BAUD_CODE_9600;
    endcase
    return ok;
  endfunction : baud_ok

  // a protocol change is refused if the held address or baud
  // would be illegal under it
  wire logic proto_ok = addr_ok(wr_data[1:0], station_address) &&
                        baud_ok(wr_data[1:0], baud_code);
  logic wr_legal;

  always_comb begin
    wr_legal = 1'b0;
    unique case (dssr_sel_t'(wr_sel))
      SEL_PROTOCOL: wr_legal = wr_data[7:2] == 6'h00 && proto_ok;
      SEL_ADDRESS: wr_legal = !wr_from_link &&
                              addr_ok(protocol_sel, wr_data);
      SEL_BAUD: wr_legal = !wr_from_link && wr_data[7:3] == 5'h00 &&
                           baud_ok(protocol_sel, wr_data[2:0]);
      SEL_COAST: wr_legal = wr_data[7:2] == 6'h00;
    endcase
  end

  wire logic wr_take = wr_any & wr_legal;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      protocol_sel <= PROTO_RST;
      station_address <= ADDR_RST;
      baud_code <= BAUD_RST;
      coast_source <= COAST_SRC_RST;
      setting_refused <= 1'b0;
    end else begin
      setting_refused <= (wr_any & ~wr_legal) | clash;
      if (wr_take && wr_sel == SEL_PROTOCOL) protocol_sel <= wr_data[1:0];
      if (wr_take && wr_sel == SEL_ADDRESS) station_address <= wr_data;
      if (wr_take && wr_sel == SEL_BAUD) baud_code <= wr_data[2:0];
      if (wr_take && wr_sel == SEL_COAST) coast_source <= wr_data[1:0];
    end
  end

  // --------------------------------------------------------------
  // bit timing
  // --------------------------------------------------------------
  // rates double per code, so a shift of the 300 baud count gives
  // each rate; the truncated remainder makes bits run short by
  // under one clock.
  localparam logic [19:0] BIT_CYC_BASE = 20'(BIT_CYCLES_300_P);
  wire logic [19:0] bit_cycles = BIT_CYC_BASE >> baud_code;
  logic [19:0] bit_count;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bit_count <= 20'h0_0000;
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= bit_count == 20'h0_0000;
      bit_count <= bit_count == 20'h0_0000 ? bit_cycles - 20'h0_0001
                                           : bit_count - 20'h0_0001;
    end
  end

  // --------------------------------------------------------------
  // coasting command source
  // --------------------------------------------------------------
  // only valid control words update the link bit; it starts at 1
  // so the link bit asserts no coast before the first word.
  logic link_run;
  wire logic term_coast = ~coast_terminal_n;
  wire logic link_coast = ~link_run;
  logic next_coast;

  always_comb begin
    next_coast = 1'b0;
    unique case (dssr_src_t'(coast_source))
      SRC_DIGITAL: next_coast = term_coast;
      SRC_SERIAL: next_coast = link_coast;
      SRC_AND: next_coast = term_coast & link_coast;
      SRC_OR: next_coast = term_coast | link_coast;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      link_run <= 1'b1;
      coast_active <= 1'b0;
    end else begin
      if (ctrl_wr && ctrl_word[CW_VALID]) link_run <= ctrl_word[CW_COAST];
      coast_active <= next_coast;
    end
  end

  // --------------------------------------------------------------
  // speed reference decode
  // --------------------------------------------------------------
  logic [15:0] ref_word;
  // 17 bits so that -32768 keeps its magnitude
  wire logic [16:0] ref_mag = ref_word[15] ? 17'h0_0000 - {1'b1, ref_word}
                                           : {1'b0, ref_word};
  wire logic [15:0] ref_span = max_ref >= min_ref ? max_ref - min_ref
                                                  : 16'h0000;
  wire logic [32:0] ref_prod = 33'(ref_span) * 33'(ref_mag);
  wire logic [18:0] ref_scaled = ref_prod[32:REF_SHIFT];
  wire logic [19:0] ref_sum = 20'(ref_scaled) + 20'(min_ref);
  wire logic [15:0] next_target = ref_sum[19:16] != 4'h0 ? 16'hffff
                                                         : ref_sum[15:0];

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ref_word <= 16'h0000;
      speed_target <= 16'h0000;
      speed_reverse <= 1'b0;
    end else begin
      if (ref_wr) ref_word <= ref_data;
      speed_target <= next_target;
      speed_reverse <= ref_word[15];
    end
  end

  // --------------------------------------------------------------
  // overcurrent trip timer
  // --------------------------------------------------------------
  localparam logic [16:0] MS_CYC = 17'(MS_CYCLES_P);
  wire logic curr_over = out_current > current_ceiling_setting;
  logic [16:0] ms_count;
  logic [15:0] over_ms;
  wire logic ms_end = ms_count == MS_CYC - 17'h0_0001;
  wire logic delay_spent = over_ms >= trip_delay_ms;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ms_count <= 17'h0_0000;
      over_ms <= 16'h0000;
      overcurrent_trip <= 1'b0;
    end else begin
      // the timer restarts when current drops to or below the limit
      if (!curr_over) begin
        ms_count <= 17'h0_0000;
        over_ms <= 16'h0000;
      end else begin
        ms_count <= ms_end ? 17'h0_0000 : ms_count + 17'h0_0001;
        if (ms_end && !delay_spent) over_ms <= over_ms + 16'h0001;
      end
      // a trip arriving with the reset is kept
      if (curr_over && delay_spent) overcurrent_trip <= 1'b1;
      else if (trip_reset) overcurrent_trip <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // status word
  // --------------------------------------------------------------
  // combinational: each read sees that cycle's conditions
  wire logic st_at_ref = motor_speed == speed_target;
  wire logic st_serial = ~(panel_stop | hand_mode);
  wire logic st_range = out_freq > freq_low && out_freq < freq_high;
  wire logic st_run = start_present | (out_freq != 16'h0000);
  wire logic st_volt = dc_voltage < dc_low || dc_voltage > dc_high;
  wire logic st_therm = motor_hot | drive_hot | thermistor_hot;

  always_comb begin
    drive_state_word = {8'h00, status_low};
    drive_state_word[ST_SPEED_AT_REF] = st_at_ref;
    drive_state_word[ST_SERIAL_OK] = st_serial;
    drive_state_word[ST_IN_RANGE] = st_range;
    drive_state_word[ST_RUNNING] = st_run;
    drive_state_word[ST_NO_FUNC] = 1'b0;
    drive_state_word[ST_VOLT_WARN] = st_volt;
    drive_state_word[ST_CURR_LIMIT] = curr_over;
    drive_state_word[ST_THERMAL] = st_therm;
  end

  // --------------------------------------------------------------
  // output frequency word
  // --------------------------------------------------------------
  // a serial divide refreshes the word every 32 cycles; reads in
  // between see the last figure, traded for a small divider.
  wire logic freq_span_ok = freq_high > freq_low;
  wire logic [15:0] freq_span = freq_span_ok ? freq_high - freq_low
                                             : 16'h0001;
  wire logic [15:0] freq_off = freq_span_ok && out_freq > freq_low
                               ? out_freq - freq_low : 16'h0000;
  wire logic [29:0] div_num = {freq_off, 14'h0000};
  logic div_busy;
  logic div_done;
  logic div_start;
  logic [29:0] div_quot;
  logic held_reverse;

  dssr_divider u_divider (
    .sys_clk(sys_clk),
    .reset(reset),
    .start(div_start),
    .dividend(div_num),
    .divisor(freq_span),
    .busy(div_busy),
    .done(div_done),
    .quotient(div_quot)
  );

  wire logic [15:0] quot_sat = div_quot > 30'(WORD_MAX) ? WORD_MAX
                                                         : div_quot[15:0];
  wire logic [15:0] next_freq_word = held_reverse ? 16'h0000 - quot_sat
                                                  : quot_sat;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      div_start <= 1'b0;
      held_reverse <= 1'b0;
      output_freq_word <= 16'h0000;
    end else begin
      div_start <= ~div_busy & ~div_start;
      if (div_start) held_reverse <= out_reverse;
      if (div_done) output_freq_word <= next_freq_word;
    end
  end

endmodule : dssr_top

//--- sim/dssr_checker.sv
// checker for the status word and link setting refusals
// assumes it is bound to dssr_top and sees only its ports
`timescale 1ns/100ps
module dssr_checker
  import dssr_pkg::*;
(
  input logic sys_clk, // clock
  input logic reset, // async reset
  input logic panel_wr, // panel strobe
  input logic serial_wr, // link strobe
  input logic [1:0] serial_sel, // link select
  input logic setting_refused, // refusal pulse
  input logic [7:0] station_address, // address
  input logic [2:0] baud_code, // bit rate code
  input logic [15:0] motor_speed, // actual speed
  input logic [15:0] speed_target, // decoded target
  input logic [15:0] out_freq, // output frequency
  input logic [15:0] freq_low, // low limit
  input logic [15:0] freq_high, // high limit
  input logic start_present, // start
  input logic panel_stop, // panel stop
  input logic hand_mode, // hand mode
  input logic [15:0] dc_voltage, // dc bus
  input logic [15:0] dc_low, // dc low bound
  input logic [15:0] dc_high, // dc high bound
  input logic [15:0] out_current, // current
  input logic [15:0] current_ceiling_setting, // limit
  input logic motor_hot, // motor hot
  input logic drive_hot, // drive hot
  input logic thermistor_hot, // thermistor hot
  input logic [7:0] status_low, // low byte
  input logic coast_active, // coasting
  input logic overcurrent_trip, // trip
  input logic [15:0] drive_state_word // status word
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  property p_speed; drive_state_word[8] == (motor_speed == speed_target);
  endproperty
  a_speed: assert property (p_speed) else $error("speed bit");
  property p_serial; drive_state_word[9] == !(panel_stop || hand_mode);
  endproperty
  a_serial: assert property (p_serial) else $error("serial bit");
  property p_range;
    drive_state_word[10] == (out_freq > freq_low && out_freq < freq_high);
  endproperty
  a_range: assert property (p_range) else $error("range bit");
  property p_run; drive_state_word[11] == (start_present || out_freq != 0);
  endproperty
  a_run: assert property (p_run) else $error("running bit");
  property p_volt;
    drive_state_word[13] == (dc_voltage < dc_low || dc_voltage > dc_high);
  endproperty
  a_volt: assert property (p_volt) else $error("voltage bit");
  property p_curr;
    drive_state_word[14] == (out_current > current_ceiling_setting);
  endproperty
  a_curr: assert property (p_curr) else $error("current bit");
  property p_hot;
    drive_state_word[15] == (motor_hot || drive_hot || thermistor_hot);
  endproperty
  a_hot: assert property (p_hot) else $error("thermal bit");
  property p_live;
    !drive_state_word[12] && drive_state_word[7:0] == status_low;
  endproperty
  a_live: assert property (p_live) else $error("live bits");
  property p_addr; serial_wr && !panel_wr && serial_sel == SEL_ADDRESS
    |=> setting_refused && $stable(station_address); endproperty
  a_addr: assert property (p_addr) else $error("link address");
  property p_baud; serial_wr && !panel_wr && serial_sel == SEL_BAUD
    |=> setting_refused && $stable(baud_code); endproperty
  a_baud: assert property (p_baud) else $error("link baud");
  c_refuse: cover property (setting_refused);
  c_coast: cover property ($rose(coast_active));
  c_trip: cover property ($rose(overcurrent_trip));
endmodule : dssr_checker

//--- sim/dssr_link_master.sv
// serial master model: setting, control word and reference writes
// assumes calls just after a rising edge; one drive on the link
`timescale 1ns/100ps
module dssr_link_master
  import dssr_pkg::*;
(
  input wire logic sys_clk, // clock
  output logic serial_wr = 1'b0, // setting strobe
  output logic [1:0] serial_sel = 2'h0, // setting select
  output logic [7:0] serial_data = 8'h00, // setting value
  output logic ctrl_wr = 1'b0, // control strobe
  output logic [15:0] ctrl_word = 16'h0000, // control word
  output logic ref_wr = 1'b0, // reference strobe
  output logic [15:0] ref_data = 16'h0000 // reference value
);
  // released lines show the inverse of the last value
  task automatic lw(input logic [1:0] s, input logic [7:0] d);
    {serial_sel, serial_data, serial_wr} = {s, d, 1'b1};
    @(posedge sys_clk) #1;
    {serial_sel, serial_data, serial_wr} = {~s, ~d, 1'b0};
  endtask : lw
  task automatic cw(input logic [15:0] w);
    {ctrl_word, ctrl_wr} = {w, 1'b1};
    @(posedge sys_clk) #1;
    {ctrl_word, ctrl_wr} = {~w, 1'b0};
  endtask : cw
  // reverse is sent as two's complement of the magnitude
  task automatic rw(input logic [15:0] r);
    {ref_data, ref_wr} = {r, 1'b1};
    @(posedge sys_clk) #1;
    {ref_data, ref_wr} = {~r, 1'b0};
  endtask : rw
endmodule : dssr_link_master

//--- sim/testbench.sv
// self-checking bench for dssr_top with a link master model
// assumes short bit and millisecond counts set by parameters
`timescale 1ns/100ps
module testbench;
  import dssr_pkg::*;
  logic sys_clk = 0, reset = 1, panel_wr = 0, coast_terminal_n = 1;
  logic out_reverse = 0, start_present = 0, panel_stop = 0, hand_mode = 0;
  logic trip_reset = 0, motor_hot = 0, drive_hot = 0, thermistor_hot = 0;
  logic [1:0] panel_sel = 0;
  logic [7:0] panel_data = 0, status_low = 0;
  logic [15:0] min_ref = 0, max_ref = 0, motor_speed = 0, out_freq = 0;
  logic [15:0] freq_low = 0, freq_high = 0, dc_voltage = 0, dc_low = 100;
  logic [15:0] dc_high = 3000, out_current = 0, trip_delay_ms = 3;
  logic [15:0] current_ceiling_setting = 16'h8000;
  wire logic serial_wr, ctrl_wr, ref_wr;
  wire logic [1:0] serial_sel;
  wire logic [7:0] serial_data;
  wire logic [15:0] ctrl_word, ref_data;
  logic setting_refused, baud_tick, coast_active, speed_reverse;
  logic overcurrent_trip;
  logic [1:0] protocol_sel, coast_source;
  logic [7:0] station_address;
  logic [2:0] baud_code;
  logic [15:0] speed_target, drive_state_word, output_freq_word, d;
  int fail_count = 0, checks_done = 0, i, j, n;
  longint e, m, s;
  logic [31:0] lfsr = 32'h7169_0cde, r;
  // sel, data, refused
  logic [10:0] steps [17] = '{11'h201, 11'h3ee, 11'h3f1, 11'h001,
    11'h002, 11'h3fe, 11'h409, 11'h2c4, 11'h004, 11'h2c7, 11'h407,
    11'h408, 11'h003, 11'h000, 11'h2fc, 11'h2ff, 11'h40d};
  always #5 sys_clk = ~sys_clk;
  dssr_top #(.BIT_CYCLES_300_P(64), .MS_CYCLES_P(10)) uut (.*);
  dssr_link_master lm (.*);
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic pw(input logic [1:0] sl, input logic [7:0] dt);
    tick(1);
    panel_sel = sl;
    panel_data = dt;
    panel_wr = 1;
    tick(1);
    panel_wr = 0;
  endtask : pw
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // hang guard, about 50k cycles
  initial begin
    #500_000;
    fail_count++;
    end_of_test();
  end
  initial begin
    tick(5);
    reset = 0;
    tick(1);
    chk({protocol_sel, station_address, baud_code, coast_source},
      15'h0037);
    for (i = 0; i < 4; i++) begin
      pw(SEL_PROTOCOL, i[7:0]);
      chk(protocol_sel, i[1:0]);
    end
    for (i = 0; i < 17; i++) begin
      pw(steps[i][10:9], steps[i][8:1]);
      chk(setting_refused, steps[i][0]);
    end
    chk({protocol_sel, station_address, baud_code}, 13'h03f4);
    for (i = 0; i < 6; i++) begin
      pw(SEL_BAUD, i[7:0]);
      for (j = 0; j < 2; j++) begin
        n = 0;
        do begin tick(1); n++; end while (baud_tick !== 1'b1 && n < 200);
      end
      chk(n[15:0], 16'(64 >> i));
    end
    tick(1);
    lm.lw(SEL_ADDRESS, 8'h05);
    chk({setting_refused, station_address}, 9'h17e);
    tick(1);
    lm.lw(SEL_BAUD, 8'h02);
    chk({setting_refused, baud_code}, 4'hd);
    for (i = 0; i < 4; i++) begin
      pw(SEL_COAST, i[7:0]);
      for (j = 0; j < 4; j++) begin
        coast_terminal_n = j[0];
        lm.cw({6'h01, 6'h00, j[1], 3'h0});
        tick(3);
        n = i == 0 ? !j[0] : i == 1 ? !j[1] : i == 2 ? !(j[0] | j[1]) :
          !(j[0] & j[1]);
        chk(coast_active, n[0]);
      end
    end
    for (i = 0; i < 20; i++) begin
      r = rnd();
      d = i == 0 ? 16'h8000 : i == 1 ? 16'h4000 : r[31:16];
      {max_ref, min_ref} = {r[15:0], 8'h00, r[23:16]};
      lm.rw(d);
      tick(3);
      m = $signed(d);
      s = max_ref >= min_ref ? max_ref - min_ref : 0;
      e = min_ref + ((s * (m < 0 ? -m : m)) >> 14);
      chk(speed_target, e > 65535 ? 16'hffff : e[15:0]);
      chk(speed_reverse, m < 0);
    end
    for (i = 0; i < 8; i++) begin
      r = rnd();
      freq_low = r[7:0];
      freq_high = freq_low + r[15:8];
      out_freq = r[24:16];
      motor_speed = r[26] ? speed_target : ~speed_target;
      r = rnd();
      {out_reverse, start_present, panel_stop, hand_mode} = r[3:0];
      {motor_hot, drive_hot, thermistor_hot, status_low} = r[14:4];
      {dc_voltage, out_current} = {4'h0, r[27:16], r[31:16]};
      tick(70);
      e = out_freq <= freq_low || freq_high <= freq_low ? 0 :
        ((out_freq - freq_low) << 14) / (freq_high - freq_low);
      e = e > 32767 ? 32767 : e;
      chk(output_freq_word, out_reverse ? -e[15:0] : e[15:0]);
      chk(drive_state_word, {motor_hot | drive_hot | thermistor_hot,
        out_current > 16'h8000, dc_voltage < 100 || dc_voltage > 3000, 1'b0,
        start_present || out_freq != 0,
        out_freq > freq_low && out_freq < freq_high,
        !(panel_stop || hand_mode), motor_speed == speed_target,
        status_low});
    end
    out_current = 0;
    trip_reset = 1;
    tick(2);
    trip_reset = 0;
    out_current = 16'hffff;
    tick(20);
    chk(overcurrent_trip, 1'b0);
    tick(25);
    chk(overcurrent_trip, 1'b1);
    end_of_test();
  end
endmodule : testbench
bind dssr_top dssr_checker chk_i (.*);
